//--- verilog/drv_enable_pkg.sv
package drv_enable_pkg;
    // -------------------------------------------------------------
    // timing
    // -------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 40_000_000;
    localparam int unsigned BAUD_MIN        = 50;
    localparam int unsigned BAUD_MAX        = 115_200;
    localparam int unsigned DIV_W           = 16;
    // 16x oversample divisor, one character of 10 bit times
    localparam int unsigned OVERSAMPLE      = 16;
    localparam int unsigned CHAR_BITS       = 10;
    localparam int unsigned CHAR_TICKS      = OVERSAMPLE * CHAR_BITS;
    localparam int unsigned TICK_W          = 8;
    localparam logic [DIV_W-1:0] DIV_RST    = 16'h0001;
    localparam int unsigned DIV_MAXRATE     = CLK_HZ / (OVERSAMPLE * BAUD_MAX);
    localparam int unsigned DIV_MINRATE     = CLK_HZ / (OVERSAMPLE * BAUD_MIN);
    // -------------------------------------------------------------
    // fifo
    // -------------------------------------------------------------
    localparam int unsigned FIFO_DEPTH      = 16;
    localparam int unsigned FIFO_AW         = 4;
    localparam int unsigned DATA_W          = 8;
    // -------------------------------------------------------------
    // activity indicator pulse
    // -------------------------------------------------------------
    localparam int unsigned LED_W           = 20;
    localparam logic [LED_W-1:0] LED_HOLD   = 20'h61a80;

    typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_HOLD} drv_state_t;
endpackage

//--- verilog/char_queue.sv
`timescale 1ns/10ps
module char_queue #(
    parameter int unsigned W  = 8,
    parameter int unsigned AW = 4
) (
    input  wire logic          ref_clk,
    input  wire logic          rst,
    input  wire logic          wr_valid,
    output      logic          wr_ready,
    input  wire logic [W-1:0]  wr_data,
    output      logic          rd_valid,
    input  wire logic          rd_ready,
    output      logic [W-1:0]  rd_data
);
    logic [W-1:0]  mem_ff [2**AW];
    logic [AW:0]   wp_ff;
    logic [AW:0]   rp_ff;
    logic [AW:0]   nxt_wp;
    logic [AW:0]   nxt_rp;
    logic          do_wr;
    logic          do_rd;
    logic [W-1:0]  rd_data_ff;
    logic [W-1:0]  nxt_rd_data;

    // -------------------------------------------------------------
    // pointers
    // -------------------------------------------------------------
    always_comb begin
        wr_ready = (wp_ff - rp_ff) != (AW+1)'(2**AW);
        rd_valid = wp_ff != rp_ff;
        do_wr    = wr_valid && wr_ready;
        do_rd    = rd_valid && rd_ready;
        nxt_wp   = do_wr ? wp_ff + 1'b1 : wp_ff;
        nxt_rp   = do_rd ? rp_ff + 1'b1 : rp_ff;
        nxt_rd_data = mem_ff[nxt_rp[AW-1:0]];
        if (do_wr && nxt_rp[AW-1:0] == wp_ff[AW-1:0]) begin
            nxt_rd_data = wr_data;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wp_ff      <= '0;
            rp_ff      <= '0;
            rd_data_ff <= '0;
        end else begin
            wp_ff      <= nxt_wp;
            rp_ff      <= nxt_rp;
            rd_data_ff <= nxt_rd_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (do_wr) begin
            mem_ff[wp_ff[AW-1:0]] <= wr_data;
        end
    end

    assign rd_data = rd_data_ff;
endmodule

//--- verilog/rs485_driver_enable_control.sv
`timescale 1ns/10ps
module rs485_driver_enable_control #(
    parameter int unsigned DEPTH_AW = drv_enable_pkg::FIFO_AW,
    parameter logic [drv_enable_pkg::LED_W-1:0] LED_CYCLES =
        drv_enable_pkg::LED_HOLD
) (
    input  wire logic                              ref_clk,
    input  wire logic                              rst,
    input  wire logic                              auto_sel,
    input  wire logic                              rts_sel,
    input  wire logic                              rts_bit,
    input  wire logic                              cts,
    input  wire logic [drv_enable_pkg::DIV_W-1:0]  baud_div,
    input  wire logic                              tx_valid,
    output      logic                              tx_ready,
    input  wire logic [drv_enable_pkg::DATA_W-1:0] tx_data,
    output      logic                              rx_valid,
    input  wire logic                              rx_ready,
    output      logic [drv_enable_pkg::DATA_W-1:0] rx_data,
    output      logic                              rx_overrun,
    output      logic                              line_tx,
    input  wire logic                              line_rx,
    output      logic                              driver_en,
    output      logic                              rx_en_n,
    output      logic                              tx_led,
    output      logic                              rx_led,
    output      logic                              cfg_error
);
    import drv_enable_pkg::*;

    // -------------------------------------------------------------
    // baud tick from divisor
    // -------------------------------------------------------------
    logic [DIV_W-1:0] bcnt_ff, nxt_bcnt;
    logic             tick;
    logic [DIV_W-1:0] div_eff;
    always_comb begin
        div_eff  = (baud_div == '0) ? DIV_RST : baud_div;
        tick     = bcnt_ff >= div_eff - 1'b1;
        nxt_bcnt = tick ? '0 : bcnt_ff + 1'b1;
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) bcnt_ff <= '0;
        else     bcnt_ff <= nxt_bcnt;
    end

    // -------------------------------------------------------------
    // queues
    // -------------------------------------------------------------
    logic              txq_valid, txq_take;
    logic [DATA_W-1:0] txq_data;
    logic              rxq_ready, rxq_push;
    logic [DATA_W-1:0] rx_shift_ff, nxt_rx_shift;
    char_queue #(.W(DATA_W), .AW(DEPTH_AW)) u_txq (
        .ref_clk (ref_clk),
        .rst     (rst),
        .wr_valid(tx_valid),
        .wr_ready(tx_ready),
        .wr_data (tx_data),
        .rd_valid(txq_valid),
        .rd_ready(txq_take),
        .rd_data (txq_data)
    );
    char_queue #(.W(DATA_W), .AW(DEPTH_AW)) u_rxq (
        .ref_clk (ref_clk),
        .rst     (rst),
        .wr_valid(rxq_push),
        .wr_ready(rxq_ready),
        .wr_data (rx_shift_ff),
        .rd_valid(rx_valid),
        .rd_ready(rx_ready),
        .rd_data (rx_data)
    );

    // -------------------------------------------------------------
    // transmitter and driver enable
    // -------------------------------------------------------------
    drv_state_t        st_ff, nxt_st;
    logic [TICK_W-1:0] tt_ff, nxt_tt;
    logic [9:0]        tsh_ff, nxt_tsh;
    logic              txo_ff, nxt_txo;
    logic              den_ff, nxt_den;
    always_comb begin
        nxt_st   = st_ff;
        nxt_tt   = tt_ff;
        nxt_tsh  = tsh_ff;
        nxt_txo  = txo_ff;
        txq_take = 1'b0;
        case (st_ff)
            ST_IDLE: begin
                if (txq_valid && cts) begin
                    txq_take = 1'b1;
                    nxt_tsh  = {1'b1, txq_data, 1'b0};
                    nxt_tt   = '0;
                    nxt_st   = ST_SEND;
                end
            end
            ST_SEND: begin
                if (tick) begin
                    nxt_tt = tt_ff + 1'b1;
                    if (tt_ff[3:0] == 4'h0) begin
                        nxt_txo = tsh_ff[0];
                        nxt_tsh = {1'b1, tsh_ff[9:1]};
                    end
                    if (tt_ff == TICK_W'(CHAR_TICKS - 1)) begin
                        nxt_tt = '0;
                        if (txq_valid && cts) begin
                            txq_take = 1'b1;
                            nxt_tsh  = {1'b1, txq_data, 1'b0};
                        end else begin
                            nxt_st = ST_HOLD;
                        end
                    end
                end
            end
            default: begin
                nxt_txo = 1'b1;
                if (txq_valid && cts) begin
                    txq_take = 1'b1;
                    nxt_tsh  = {1'b1, txq_data, 1'b0};
                    nxt_tt   = '0;
                    nxt_st   = ST_SEND;
                end else if (tick) begin
                    nxt_tt = tt_ff + 1'b1;
                    if (tt_ff == TICK_W'(CHAR_TICKS)) begin
                        nxt_st = ST_IDLE;
                    end
                end
            end
        endcase
        if (auto_sel) begin
            nxt_den = txq_valid || nxt_st != ST_IDLE;
        end else if (rts_sel) begin
            nxt_den = rts_bit;
        end else begin
            nxt_den = 1'b0;
        end
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_ff  <= ST_IDLE;
            tt_ff  <= '0;
            tsh_ff <= '1;
            txo_ff <= 1'b1;
            den_ff <= 1'b0;
        end else begin
            st_ff  <= nxt_st;
            tt_ff  <= nxt_tt;
            tsh_ff <= nxt_tsh;
            txo_ff <= nxt_txo;
            den_ff <= nxt_den;
        end
    end
    assign line_tx   = txo_ff;
    assign driver_en = den_ff;
    assign rx_en_n   = den_ff;
    assign cfg_error = auto_sel == rts_sel;

    // -------------------------------------------------------------
    // receiver, input held at mark while driving, so no new start bit is seen
    // -------------------------------------------------------------
    logic              rbusy_ff, nxt_rbusy;
    logic [TICK_W-1:0] rt_ff, nxt_rt;
    logic              rin;
    logic              ovr_ff, nxt_ovr;
    always_comb begin
        rin          = line_rx | den_ff;
        nxt_rbusy    = rbusy_ff;
        nxt_rt       = rt_ff;
        nxt_rx_shift = rx_shift_ff;
        rxq_push     = 1'b0;
        nxt_ovr      = ovr_ff;
        if (!rbusy_ff) begin
            if (!rin) begin
                nxt_rbusy = 1'b1;
                nxt_rt    = '0;
            end
        end else if (tick) begin
            nxt_rt = rt_ff + 1'b1;
            if (rt_ff[3:0] == 4'h7 && rt_ff[7:4] != 4'h0
                && rt_ff[7:4] != 4'h9) begin
                nxt_rx_shift = {rin, rx_shift_ff[7:1]};
            end
            if (rt_ff == 8'h97) begin
                nxt_rbusy = 1'b0;
                rxq_push  = rin;
                nxt_ovr   = ovr_ff | (rin & ~rxq_ready);
            end
        end
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rbusy_ff    <= 1'b0;
            rt_ff       <= '0;
            rx_shift_ff <= '0;
            ovr_ff      <= 1'b0;
        end else begin
            rbusy_ff    <= nxt_rbusy;
            rt_ff       <= nxt_rt;
            rx_shift_ff <= nxt_rx_shift;
            ovr_ff      <= nxt_ovr;
        end
    end
    assign rx_overrun = ovr_ff;

    // -------------------------------------------------------------
    // activity indicators
    // -------------------------------------------------------------
    logic             ptx_ff, prx_ff;
    logic [LED_W-1:0] ltx_ff, lrx_ff, nxt_ltx, nxt_lrx;
    always_comb begin
        nxt_ltx = (txo_ff != ptx_ff) ? LED_CYCLES :
                  (ltx_ff != '0) ? ltx_ff - 1'b1 : ltx_ff;
        nxt_lrx = (line_rx != prx_ff) ? LED_CYCLES :
                  (lrx_ff != '0) ? lrx_ff - 1'b1 : lrx_ff;
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ptx_ff <= 1'b1;
            prx_ff <= 1'b1;
            ltx_ff <= '0;
            lrx_ff <= '0;
        end else begin
            ptx_ff <= txo_ff;
            prx_ff <= line_rx;
            ltx_ff <= nxt_ltx;
            lrx_ff <= nxt_lrx;
        end
    end
    assign tx_led = ltx_ff != '0;
    assign rx_led = lrx_ff != '0;

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    a_auto_pending: assert property (@(posedge ref_clk) disable iff (rst)
        auto_sel && txq_valid |=> driver_en)
        else $error("driver not enabled with data pending");
    a_manual_rts: assert property (@(posedge ref_clk) disable iff (rst)
        !auto_sel && rts_sel |=> driver_en == $past(rts_bit))
        else $error("driver does not follow rts");
    a_hold_state: assert property (@(posedge ref_clk) disable iff (rst)
        st_ff == ST_SEND && nxt_st == ST_HOLD && auto_sel
        |=> driver_en [*2])
        else $error("driver dropped at end of character");
    a_idle_off: assert property (@(posedge ref_clk) disable iff (rst)
        auto_sel && st_ff == ST_IDLE && !txq_valid |=> !driver_en)
        else $error("driver on while idle");
    a_cts_gate: assert property (@(posedge ref_clk) disable iff (rst)
        txq_take |-> cts)
        else $error("character started without cts");
    a_half_duplex: assert property (@(posedge ref_clk) disable iff (rst)
        driver_en |-> rx_en_n)
        else $error("receiver on while driving");
    a_rx_quiet: assert property (@(posedge ref_clk) disable iff (rst)
        driver_en && !rbusy_ff |=> !rbusy_ff)
        else $error("receiver started while driving");
    a_tick_div: assert property (@(posedge ref_clk) disable iff (rst)
        tick && baud_div > 16'h0001 && $stable(baud_div) |=> !tick)
        else $error("tick faster than divisor");
    a_led_tx: assert property (@(posedge ref_clk) disable iff (rst)
        txo_ff != ptx_ff |=> tx_led)
        else $error("tx activity not shown");
    a_cfg_flag: assert property (@(posedge ref_clk) disable iff (rst)
        auto_sel && rts_sel |-> cfg_error)
        else $error("bad config not flagged");
    c_auto_send: cover property (@(posedge ref_clk) disable iff (rst)
        auto_sel && st_ff == ST_HOLD ##1 st_ff == ST_IDLE);
    c_manual_on: cover property (@(posedge ref_clk) disable iff (rst)
        rts_sel && !auto_sel && driver_en);
    c_rx_push: cover property (@(posedge ref_clk) disable iff (rst)
        rxq_push);
endmodule

//--- tb/rs485_node.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// far node on the shared pair, talks only when the line is free
// ---------------------------------------------------------------
module rs485_node (
    input  wire logic        ref_clk,
    input  wire logic        driver_en,
    input  wire logic        send,
    input  wire logic [7:0]  data,
    input  wire logic [15:0] bit_clks,
    output      logic        line_rx
);
    logic [9:0] frame;

    // bias holds the pair at mark while nobody drives
    initial line_rx = 1'b1;

    always @(posedge ref_clk) begin
        if (send) begin
            frame = {1'b1, data, 1'b0};
            while (driver_en) @(posedge ref_clk);
            for (int i = 0; i < 10; i++) begin
                line_rx <= frame[i];
                repeat (bit_clks) @(posedge ref_clk);
            end
        end
    end
endmodule

//--- tb/rs485_driver_enable_control_tb.sv
`timescale 1ns/10ps
module rs485_driver_enable_control_tb;
    import drv_enable_pkg::*;
    logic              ref_clk;
    logic              rst;
    logic              auto_sel;
    logic              rts_sel;
    logic              rts_bit;
    logic              cts;
    logic [DIV_W-1:0]  baud_div;
    logic              tx_valid;
    logic              tx_ready;
    logic [DATA_W-1:0] tx_data;
    logic              rx_valid;
    logic              rx_ready;
    logic [DATA_W-1:0] rx_data;
    logic              rx_overrun;
    logic              line_tx;
    logic              line_rx;
    logic              driver_en;
    logic              rx_en_n;
    logic              tx_led;
    logic              rx_led;
    logic              cfg_error;
    logic              node_send;
    logic [7:0]        node_data;
    int                num_errors;
    int                total_checks;

    rs485_driver_enable_control #(.LED_CYCLES(20'h00008))
        rs485_driver_enable_control_i (
        .ref_clk(ref_clk), .rst(rst), .auto_sel(auto_sel),
        .rts_sel(rts_sel), .rts_bit(rts_bit), .cts(cts),
        .baud_div(baud_div), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_data(tx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .rx_data(rx_data), .rx_overrun(rx_overrun), .line_tx(line_tx),
        .line_rx(line_rx), .driver_en(driver_en), .rx_en_n(rx_en_n),
        .tx_led(tx_led), .rx_led(rx_led), .cfg_error(cfg_error));

    rs485_node rs485_node_i (
        .ref_clk(ref_clk), .driver_en(driver_en), .send(node_send),
        .data(node_data), .bit_clks({baud_div[11:0], 4'h0}),
        .line_rx(line_rx));

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // ---------------------------------------------------------------
    // shared helpers
    // ---------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    function automatic logic pick(input int sel);
        case (sel)
            0: pick = line_tx;
            1: pick = line_rx;
            default: pick = rx_valid;
        endcase
    endfunction

    task automatic wait_for(input int sel, input logic v, input int bound);
        int n;
        n = 0;
        while (pick(sel) !== v) begin
            step(1);
            n++;
            if (n > bound) begin
                num_errors++;
                $display("[FAIL] %0t: wait bound used up", $time);
                finish_test();
            end
        end
    endtask

    task automatic do_reset();
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        step(1);
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic test_auto(input int div, input logic [7:0] d);
        int bitc;
        int n;
        bitc = 16 * div;
        @(posedge ref_clk);
        baud_div <= div[DIV_W-1:0];
        tx_valid <= 1'b1;
        tx_data <= d;
        @(posedge ref_clk);
        tx_valid <= 1'b0;
        step(1);
        check(driver_en, 1'b1);
        wait_for(0, 1'b0, 4 * bitc);
        step(2);
        check(tx_led, 1'b1);
        step(bitc / 2 - 2);
        check(line_tx, 1'b0);
        check(rx_en_n, driver_en);
        for (int i = 0; i < 8; i++) begin
            step(bitc);
            check(line_tx, d[i]);
        end
        step(bitc);
        check(line_tx, 1'b1);
        n = 9 * bitc + bitc / 2;
        while (driver_en === 1'b1 && n < 400 * div) begin
            step(1);
            n++;
        end
        check(n, 2 * CHAR_TICKS * div);
        step(10 * div);
        check(driver_en, 1'b0);
        check(tx_led, 1'b0);
        $display("auto transmit at divisor %0d done", div);
    endtask

    task automatic test_rx();
        @(posedge ref_clk);
        node_data <= 8'ha5;
        node_send <= 1'b1;
        @(posedge ref_clk);
        node_send <= 1'b0;
        wait_for(1, 1'b0, 100);
        step(2);
        check(rx_led, 1'b1);
        check(driver_en, 1'b0);
        check(rx_valid, 1'b0);
        wait_for(2, 1'b1, 25000);
        check(rx_data, 8'ha5);
        check(rx_overrun, 1'b0);
        @(posedge ref_clk);
        rx_ready <= 1'b1;
        @(posedge ref_clk);
        rx_ready <= 1'b0;
        step(1);
        check(rx_valid, 1'b0);
        $display("receive done");
    endtask

    task automatic test_manual();
        @(posedge ref_clk);
        auto_sel <= 1'b0;
        rts_sel <= 1'b1;
        rts_bit <= 1'b1;
        step(2);
        check(driver_en, 1'b1);
        check(cfg_error, 1'b0);
        @(posedge ref_clk);
        rts_bit <= 1'b0;
        step(2);
        check(driver_en, 1'b0);
        @(posedge ref_clk);
        rts_sel <= 1'b0;
        rts_bit <= 1'b1;
        step(2);
        check(cfg_error, 1'b1);
        check(driver_en, 1'b0);
        @(posedge ref_clk);
        auto_sel <= 1'b1;
        rts_sel <= 1'b1;
        step(1);
        check(cfg_error, 1'b1);
        @(posedge ref_clk);
        rts_sel <= 1'b0;
        rts_bit <= 1'b0;
        step(2);
        $display("manual control done");
    endtask

    task automatic test_cts_fill();
        int acc;
        acc = 0;
        @(posedge ref_clk);
        cts <= 1'b0;
        tx_valid <= 1'b1;
        tx_data <= 8'h3c;
        for (int k = 0; k < 20; k++) begin
            #1;
            acc += int'(tx_ready === 1'b1);
            @(posedge ref_clk);
        end
        tx_valid <= 1'b0;
        check(acc, 32'h00000010);
        step(400);
        check(line_tx, 1'b1);
        $display("queue fill without clear to send done");
        do_reset();
        @(posedge ref_clk);
        cts <= 1'b1;
    endtask

    initial begin
        num_errors = 0;
        total_checks = 0;
        rst = 1'b1;
        auto_sel = 1'b1;
        rts_sel = 1'b0;
        rts_bit = 1'b0;
        cts = 1'b1;
        baud_div = 16'h0042;
        tx_valid = 1'b0;
        tx_data = 8'h00;
        rx_ready = 1'b0;
        node_send = 1'b0;
        node_data = 8'h00;
        do_reset();
        test_auto(66, 8'h5a);
        test_auto(130, 8'hc3);
        test_rx();
        test_manual();
        test_cts_fill();
        finish_test();
    end
endmodule
